// *** src/irah_host.sv ***
/*
  I2C host that reaches the sensor's 256-byte register space:
  burst writes, burst reads and the two general-call commands.
  Assumes a user that feeds write bytes on request and an
  open-drain bus resolved outside from the enables.
*/
`timescale 1ns/10ps
// Operation
// RQ1 - General call 0x06 resets the sensor
// RQ2 - General call 0x04 reloads slave address
// RQ3 - Reload touches only address bits two to six
// RQ4 - Single write: address, register, data, STOP
// RQ5 - Bytes after register address are write data
// RQ6 - Sensor pointer advances after each written byte
// RQ7 - Burst never passes top of register space
// RQ8 - Read: write register address, then readdress
// RQ9 - Single read answered, master NACKs then STOP
// RQ10 - Sensor sends bytes while master acknowledges
// RQ11 - Sensor pointer advances after each sent byte
// RQ12 - Last read byte NACKed, then STOP
// RQ13 - Plain registers written only between frames
// RQ14 - Shadowed writes take effect next frame
// RQ15 - Commands accepted in any order
// RQ16 - Write takes n plus two bytes
// RQ17 - Read takes n plus three bytes
// RQ18 - EEPROM write needs twenty milliseconds
// RQ19 - Reserved registers are never written
// RQ20 - Reset restores factory register values
// RQ21 - Seven-bit addressing only
// RQ22 - Straps low give address 0100000
// RQ23 - Register space is 256 bytes
// RQ24 - Wide registers stored high byte first
// RQ25 - Sensor acknowledges own address and writes
module irah_host #(
  parameter int EE_WAIT_CYCLES = irah_pkg::EE_WAIT_CYC,
  parameter logic [255:0] RESV_MAP = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input irah_pkg::irah_cmd_s cmd,
  // Write data
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Read data and status
  output logic [7:0] rd_data,
  output logic rd_valid,
  output irah_pkg::irah_stat_s stat,
  // Frame acquisition level from the sensor
  input wire logic frame_busy,
  // I2C pins, open-drain
  input wire logic scl_in,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe
);
  import irah_pkg::*;
  localparam int WC_W = $clog2(EE_WAIT_CYCLES + 1);

  irah_state_e state_reg, state_next;
  irah_seg_e seg_reg, seg_next;
  irah_cmd_s cmd_reg, cmd_next;
  irah_err_e err_reg, err_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bitcnt_reg, bitcnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [8:0] left_reg, left_next;
  logic [8:0] bytes_reg, bytes_next;
  logic [WC_W-1:0] wcnt_reg, wcnt_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic done_reg, done_next;
  logic pend_reg;
  logic [SYNC_W-1:0] sync_q;
  logic be_done;
  logic be_rx;
  irah_bit_e be_cmd;

  irah_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({frame_busy, scl_in, sda_in}),
    .q(sync_q)
  );

  wire frame_busy_s = sync_q[2];
  wire is_gc = cmd_reg.op[1];
  wire is_rd = cmd_reg.op == OP_READ;
  wire acc = cmd_valid && cmd_ready;
  wire [9:0] end_addr = 10'(cmd.reg_addr) + 10'(cmd.count);
  // Burst must stay inside the register space [RQ7] [RQ23]
  wire range_ok = cmd.op[1] ||
                  (cmd.count != 9'h0 && end_addr <= 10'(REG_SPACE));
  // Only unshadowed writes wait for the frame [RQ13] [RQ14] [RQ15]
  wire hold_frame = cmd.op == OP_WRITE && !cmd.shadowed && frame_busy_s;
  wire be_act = state_reg inside {ST_START, ST_TXBIT, ST_TXACK,
                                  ST_RXBIT, ST_RXACK, ST_STOP};
  wire be_go = be_act && !pend_reg;
  wire last_rx = left_reg == 9'h0;
  // Acknowledge every byte but the last [RQ9] [RQ10] [RQ12]
  wire be_bit = (state_reg == ST_RXACK) ? last_rx : shift_reg[7];
  wire resv_hit = RESV_MAP[ptr_reg];
  wire wait_end = wcnt_reg == WC_W'(EE_WAIT_CYCLES - 1);
  wire ee_tail = cmd_reg.eeprom && err_reg == ERR_NONE && !is_rd;
  // Seven-bit address, direction in bit zero [RQ21]
  wire [7:0] byte_addr_w = is_gc ? GC_ADDR_BYTE : {cmd_reg.dev_addr, 1'b0};
  wire [7:0] byte_addr_r = {cmd_reg.dev_addr, 1'b1};
  // General-call codes [RQ1] [RQ2]
  wire [7:0] byte_reg = (cmd_reg.op == OP_GC_RESET) ? GC_RESET_CODE :
                        (cmd_reg.op == OP_GC_RELOAD) ? GC_RELOAD_CODE :
                        cmd_reg.reg_addr;

  assign be_cmd = (state_reg == ST_START) ? BE_START :
                  (state_reg == ST_STOP) ? BE_STOP :
                  (state_reg == ST_TXACK || state_reg == ST_RXBIT) ?
                  BE_READ : BE_WRITE;
  assign cmd_ready = state_reg == ST_IDLE && !hold_frame;
  assign wr_ready = state_reg == ST_FETCH;

  irah_bit_engine u_bit (
    .clk(clk),
    .arst_n(arst_n),
    .go(be_go),
    .op(be_cmd),
    .bit_in(be_bit),
    .done(be_done),
    .bit_out(be_rx),
    .scl_s(sync_q[1]),
    .sda_s(sync_q[0]),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  always_comb begin
    state_next = state_reg;
    seg_next = seg_reg;
    cmd_next = cmd_reg;
    err_next = err_reg;
    shift_next = shift_reg;
    bitcnt_next = bitcnt_reg;
    ptr_next = ptr_reg;
    left_next = left_reg;
    bytes_next = bytes_reg;
    wcnt_next = wcnt_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (acc) begin
          cmd_next = cmd;
          bytes_next = 9'h0;
          if (!range_ok) begin
            done_next = 1'b1;
            err_next = ERR_RANGE;
          end else begin
            err_next = ERR_NONE;
            state_next = ST_START;
            seg_next = SEG_ADDR_W;
            ptr_next = cmd.reg_addr;
            left_next = cmd.count;
          end
        end
      end
      ST_START: begin
        if (be_done) begin
          state_next = ST_TXBIT;
          bitcnt_next = BIT_LAST;
          shift_next = (seg_reg == SEG_ADDR_R) ? byte_addr_r : byte_addr_w;
        end
      end
      ST_TXBIT: begin
        if (be_done) begin
          shift_next = {shift_reg[6:0], 1'b0};
          bitcnt_next = bitcnt_reg - 3'h1;
          if (bitcnt_reg == 3'h0) begin
            state_next = ST_TXACK;
          end
        end
      end
      ST_TXACK: begin
        if (be_done) begin
          bytes_next = bytes_reg + 9'h1;
          bitcnt_next = BIT_LAST;
          if (be_rx) begin
            // No acknowledge: give up and free the bus [RQ25]
            err_next = ERR_NACK;
            state_next = ST_STOP;
          end else begin
            case (seg_reg)
              SEG_ADDR_W: begin
                seg_next = SEG_REG;
                shift_next = byte_reg;
                state_next = ST_TXBIT;
              end
              SEG_REG: begin
                if (is_gc) begin
                  state_next = ST_STOP;
                end else if (is_rd) begin
                  // Readdress for reading after the pointer [RQ8]
                  seg_next = SEG_ADDR_R;
                  state_next = ST_START;
                end else begin
                  // Data follows the register address [RQ4]
                  seg_next = SEG_WDATA;
                  state_next = ST_FETCH;
                end
              end
              SEG_ADDR_R: begin
                seg_next = SEG_RDATA;
                state_next = ST_RXBIT;
              end
              default: begin
                // Byte count n plus two on the bus [RQ16]
                state_next = (left_reg == 9'h0) ? ST_STOP : ST_FETCH;
              end
            endcase
          end
        end
      end
      ST_FETCH: begin
        if (wr_valid) begin
          if (resv_hit) begin
            // Reserved register: abort before touching it [RQ19]
            err_next = ERR_RESV;
            state_next = ST_STOP;
          end else begin
            shift_next = wr_data;
            bitcnt_next = BIT_LAST;
            ptr_next = ptr_reg + 8'h1;
            left_next = left_reg - 9'h1;
            state_next = ST_TXBIT;
          end
        end
      end
      ST_RXBIT: begin
        if (be_done) begin
          shift_next = {shift_reg[6:0], be_rx};
          bitcnt_next = bitcnt_reg - 3'h1;
          if (bitcnt_reg == 3'h0) begin
            state_next = ST_RXACK;
            rd_data_next = {shift_reg[6:0], be_rx};
            rd_valid_next = 1'b1;
            ptr_next = ptr_reg + 8'h1;
            left_next = left_reg - 9'h1;
          end
        end
      end
      ST_RXACK: begin
        if (be_done) begin
          // Byte count n plus three on the bus [RQ17]
          bytes_next = bytes_reg + 9'h1;
          bitcnt_next = BIT_LAST;
          state_next = last_rx ? ST_STOP : ST_RXBIT;
        end
      end
      ST_STOP: begin
        if (be_done) begin
          if (ee_tail) begin
            state_next = ST_WAIT;
            wcnt_next = '0;
          end else begin
            state_next = ST_IDLE;
            done_next = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // EEPROM programming time before the next command [RQ18]
        wcnt_next = wcnt_reg + WC_W'(1);
        if (wait_end) begin
          state_next = ST_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      seg_reg <= SEG_ADDR_W;
      cmd_reg <= '0;
      err_reg <= ERR_NONE;
      shift_reg <= 8'h00;
      bitcnt_reg <= 3'h0;
      ptr_reg <= 8'h00;
      left_reg <= 9'h000;
      bytes_reg <= 9'h000;
      wcnt_reg <= '0;
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seg_reg <= seg_next;
      cmd_reg <= cmd_next;
      err_reg <= err_next;
      shift_reg <= shift_next;
      bitcnt_reg <= bitcnt_next;
      ptr_reg <= ptr_next;
      left_reg <= left_next;
      bytes_reg <= bytes_next;
      wcnt_reg <= wcnt_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      done_reg <= done_next;
      pend_reg <= be_go ? 1'b1 : (be_done ? 1'b0 : pend_reg);
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign stat = {state_reg != ST_IDLE, done_reg, err_reg};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_tx_ack(irah_seg_e sg);
    state_reg == ST_TXACK && be_done && !be_rx && seg_reg == sg;
  endsequence
  sequence s_stop_ok;
    state_reg == ST_STOP && be_done && err_reg == ERR_NONE;
  endsequence

  property p_rq1;
    s_tx_ack(SEG_ADDR_W) ##0 cmd_reg.op == OP_GC_RESET
      |=> shift_reg == GC_RESET_CODE && state_reg == ST_TXBIT;
  endproperty
  a_rq1: assert property (p_rq1) else $error("reset code not sent"); // [RQ1]

  property p_rq4;
    s_tx_ack(SEG_REG) ##0 cmd_reg.op == OP_WRITE
      |=> state_reg == ST_FETCH && seg_reg == SEG_WDATA;
  endproperty
  a_rq4: assert property (p_rq4) else $error("no data after reg"); // [RQ4]

  property p_rq8;
    s_tx_ack(SEG_REG) ##0 is_rd |=> state_reg == ST_START
      ##[1:300] (state_reg == ST_TXBIT && shift_reg == byte_addr_r);
  endproperty
  a_rq8: assert property (p_rq8) else $error("bad read readdress"); // [RQ8]

  // Checked at the pin: the engine drives the ack two clocks after go
  property p_rq9;
    state_reg == ST_RXACK && be_go && last_rx |-> ##2 !sda_oe;
  endproperty
  a_rq9: assert property (p_rq9) else $error("last byte not NACKed"); // [RQ9]

  property p_rq10;
    state_reg == ST_RXACK && be_go && !last_rx |-> ##2 sda_oe;
  endproperty
  a_rq10: assert property (p_rq10) else $error("mid byte NACKed"); // [RQ10]

  property p_rq12;
    state_reg == ST_RXACK && be_done && last_rx |=> state_reg == ST_STOP;
  endproperty
  a_rq12: assert property (p_rq12) else $error("no STOP after NACK"); // [RQ12]

  property p_rq7;
    acc && !range_ok |=> done_reg && err_reg == ERR_RANGE
      && state_reg == ST_IDLE;
  endproperty
  a_rq7: assert property (p_rq7) else $error("range not refused"); // [RQ7]

  property p_rq13;
    state_reg == ST_IDLE && cmd_valid && cmd.op == OP_WRITE
      && !cmd.shadowed && frame_busy_s |=> state_reg == ST_IDLE;
  endproperty
  a_rq13: assert property (p_rq13) else $error("write during frame"); // [RQ13]

  property p_rq16;
    s_stop_ok ##0 cmd_reg.op == OP_WRITE
      |-> bytes_reg == cmd_reg.count + 9'h2;
  endproperty
  a_rq16: assert property (p_rq16) else $error("write byte count"); // [RQ16]

  property p_rq17;
    s_stop_ok ##0 is_rd |-> bytes_reg == cmd_reg.count + 9'h3;
  endproperty
  a_rq17: assert property (p_rq17) else $error("read byte count"); // [RQ17]

  property p_rq18;
    s_stop_ok ##0 ee_tail |=> (!cmd_ready && !done_reg) [*8];
  endproperty
  a_rq18: assert property (p_rq18) else $error("EEPROM wait cut"); // [RQ18]
endmodule // irah_host

// *** src/irah_pkg.sv ***
/*
  Shared constants and types for the register-access I2C host.
  Assumes a 100 MHz system clock and one addressed sensor on the bus.
*/
package irah_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Bit period for FM+ at 1 MHz, split into four phases
  localparam int SCL_PERIOD_NS = 1000;
  localparam int SCL_QTR_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int QTR_W = $clog2(SCL_QTR_CYC);
  // Settling time after an indirect EEPROM write
  localparam int EE_WAIT_MS = 20;
  localparam int EE_WAIT_CYC =
    (EE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_SPACE = 256;
  localparam int SYNC_W = 3;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_CODE = 8'h06;
  localparam logic [7:0] GC_RELOAD_CODE = 8'h04;
  // Sensor address with both straps low [RQ22]
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;
  localparam logic [7:0] ADDR_CFG_REG = 8'hCA;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_GC_RESET = 2'h2,
    OP_GC_RELOAD = 2'h3
  } irah_op_e;

  typedef struct packed {
    irah_op_e op;
    logic [6:0] dev_addr;
    logic [7:0] reg_addr;
    logic [8:0] count;
    logic shadowed;
    logic eeprom;
  } irah_cmd_s;

  typedef enum logic [1:0] {
    BE_START = 2'h0,
    BE_STOP = 2'h1,
    BE_WRITE = 2'h2,
    BE_READ = 2'h3
  } irah_bit_e;

  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_NACK = 2'h1,
    ERR_RANGE = 2'h2,
    ERR_RESV = 2'h3
  } irah_err_e;

  typedef struct packed {
    logic busy;
    logic done;
    irah_err_e err;
  } irah_stat_s;

  typedef enum logic [2:0] {
    SEG_ADDR_W = 3'h0,
    SEG_REG = 3'h1,
    SEG_WDATA = 3'h2,
    SEG_ADDR_R = 3'h3,
    SEG_RDATA = 3'h4
  } irah_seg_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_TXBIT = 4'h3,
    ST_TXACK = 4'h2,
    ST_FETCH = 4'h6,
    ST_RXBIT = 4'h7,
    ST_RXACK = 4'h5,
    ST_STOP = 4'h4,
    ST_WAIT = 4'hC
  } irah_state_e;
endpackage

// *** src/irah_sync.sv ***
/*
  Two-flop synchronisers, one per bit.
  Assumes inputs are asynchronous levels; pulses shorter than one
  clock may be lost.
*/
`timescale 1ns/10ps
module irah_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_reg[i] <= 1'b0;
        q_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= d[i];
        q_reg[i] <= meta_reg[i];
      end
    end
  end

  assign q = q_reg;
endmodule // irah_sync

// *** src/irah_bit_engine.sv ***
/*
  I2C bit engine: START, STOP, one written or one read bit.
  Assumes synchronised SCL/SDA levels; drives both lines open-drain.
*/
`timescale 1ns/10ps
module irah_bit_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bit request
  input wire logic go,
  input irah_pkg::irah_bit_e op,
  input wire logic bit_in,
  output logic done,
  output logic bit_out,
  // Synchronised bus levels
  input wire logic scl_s,
  input wire logic sda_s,
  // Open-drain drives, high pulls the line low
  output logic scl_oe,
  output logic sda_oe
);
  import irah_pkg::*;

  logic act_reg;
  logic [1:0] ph_reg;
  logic [QTR_W-1:0] cnt_reg;
  irah_bit_e op_reg;
  logic bit_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic done_reg;
  logic rx_reg;

  wire ph_end = cnt_reg == QTR_W'(SCL_QTR_CYC - 1);
  // Slave holding SCL low stretches the high phase
  wire stall = !scl_oe_reg && !scl_s;
  wire step = act_reg && !stall && ph_end;
  wire is_start = op_reg == BE_START;
  wire is_stop = op_reg == BE_STOP;
  // START keeps SCL as it was so an idle bus sees no extra edge
  wire scl_drv = (ph_reg == 2'h0) ? (is_start ? scl_oe_reg : 1'b1) :
                 (ph_reg == PH_LAST) ? !is_stop : 1'b0;
  wire sda_drv = is_start ? ph_reg[1] :
                 is_stop ? !ph_reg[1] :
                 (op_reg == BE_WRITE) ? !bit_reg : 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg <= 1'b0;
      ph_reg <= 2'h0;
      cnt_reg <= '0;
      op_reg <= BE_START;
      bit_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      rx_reg <= 1'b0;
    end else begin
      done_reg <= step && ph_reg == PH_LAST;
      if (!act_reg) begin
        if (go) begin
          act_reg <= 1'b1;
          ph_reg <= 2'h0;
          cnt_reg <= '0;
          op_reg <= op;
          bit_reg <= bit_in;
        end
      end else begin
        scl_oe_reg <= scl_drv;
        sda_oe_reg <= sda_drv;
        if (!stall) begin
          cnt_reg <= ph_end ? '0 : cnt_reg + QTR_W'(1);
        end
        if (step) begin
          ph_reg <= ph_reg + 2'h1;
          act_reg <= ph_reg != PH_LAST;
        end
        if (step && ph_reg == PH_SAMPLE) begin
          rx_reg <= sda_s;
        end
      end
    end
  end

  assign done = done_reg;
  assign bit_out = rx_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
endmodule // irah_bit_engine

// *** verif/irah_dev_model.sv ***
/*
  Behavioural sensor: I2C slave over a 256-byte register space.
  Assumes SCL/SDA are pulled up and resolved outside from all enables.
*/
`timescale 1ns/10ps
module irah_dev_model (
  // Bus levels and drives, high pulls low
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  // Straps and pacing
  input wire logic [1:0] straps,
  input wire logic slow
);
  import irah_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic [4:0] hi;
  logic act, tx, go_tx, gc, nak;
  int cnt, bi;

  function automatic logic [7:0] fact(input int a);
    return 8'(a) ^ 8'hA5;
  endfunction

  task automatic hw_reset();
    for (int i = 0; i < 256; i++) mem[i] = fact(i);
    hi = DEV_ADDR_DEFAULT[6:2];
  endtask

  task automatic take_byte();
    logic ack;
    ack = 1'b1;
    if (bi == 0) begin
      gc = (sh == GC_ADDR_BYTE);
      if (!gc && sh[7:1] != {hi, straps}) begin
        ack = 1'b0;
        act = 1'b0;
      end
      go_tx = ack && sh[0] && !gc;
    end else if (gc && bi == 1) begin
      if (sh == GC_RESET_CODE) hw_reset();
      if (sh == GC_RELOAD_CODE) hi = mem[ADDR_CFG_REG][6:2];
    end else if (bi == 1) begin
      ptr = sh;
    end else begin
      mem[ptr] = sh;
      ptr = ptr + 1;
    end
    bi = bi + 1;
    sda_oe = ack;
  endtask

  initial begin
    hw_reset();
    {scl_oe, sda_oe, act, tx, go_tx, gc, nak} = '0;
  end

  always @(negedge sda) if (scl === 1'b1) begin
    {act, tx, go_tx, gc} = 4'h8;
    // The SCL fall that closes the START is not a bit
    cnt = -1;
    bi = 0;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    {act, tx, sda_oe} = '0;
  end

  always @(posedge scl) if (act) begin
    if (!tx && cnt < 8) sh = {sh[6:0], sda};
    if (tx && cnt == 8) nak = sda;
  end

  always @(negedge scl) if (act) begin
    cnt = cnt + 1;
    if (tx) sda_oe = (cnt < 8) ? !sh[7 - cnt] : 1'b0;
    else if (cnt == 8) take_byte();
    if (cnt == 9) begin
      cnt = 0;
      sda_oe = 1'b0;
      if (go_tx) begin
        {tx, go_tx, nak} = 3'h4;
      end
      if (tx && !nak) begin
        sh = mem[ptr];
        ptr = ptr + 1;
        sda_oe = !sh[7];
      end else tx = 1'b0;
    end
  end

  // Slow answer: hold SCL low past the host's own low time
  always @(negedge scl) if (act && slow) begin
    scl_oe = 1'b1;
    #700 scl_oe = 1'b0;
  end
endmodule // irah_dev_model

// *** verif/irah_host_tb.sv ***
/*
  Self-checking bench for irah_host against the sensor model.
  Assumes the model's factory register pattern is known here.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t got %0h want %0h", $time, a, b); \
  end end
module irah_host_tb;
  import irah_pkg::*;
  localparam logic [255:0] RESV = 256'h1 << 8'hF0;
  logic clk, arst_n, cmd_valid, wr_valid, frame_busy, slow, dn;
  logic cmd_ready, wr_ready, rd_valid, scl_oe, sda_oe, m_scl, m_sda;
  logic [7:0] wr_data, rd_data, ra;
  logic [6:0] dev;
  irah_cmd_s cmd;
  irah_stat_s stat;
  irah_err_e er;
  logic [7:0] wq[$], rq[$], exp_m[0:255];
  int mismatches, n_checks, busy_cyc, rises, n, d0;
  wire logic scl_w = !(scl_oe | m_scl);
  wire logic sda_w = !(sda_oe | m_sda);

  irah_host #(.EE_WAIT_CYCLES(64), .RESV_MAP(RESV)) irah_host_i (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .stat(stat), .frame_busy(frame_busy),
    .scl_in(scl_w), .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe));
  irah_dev_model irah_dev_model_i (.scl(scl_w), .sda(sda_w),
    .scl_oe(m_scl), .sda_oe(m_sda), .straps(2'b00), .slow(slow));

  function automatic logic [7:0] fact(input int a);
    return 8'(a) ^ 8'hA5;
  endfunction

  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      void'(wq.pop_front());
      wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    end
    if (rd_valid) rq.push_back(rd_data);
    if (stat.done) begin
      dn <= 1'b1;
      er <= stat.err;
    end
    if (stat.busy) busy_cyc++;
  end
  always @(posedge scl_w) rises++;

  task automatic run(input irah_op_e op, input logic [7:0] a,
      input int cnt, input logic shd, input logic ee);
    dn = 1'b0;
    busy_cyc = 0;
    rq = {};
    wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    cmd <= '{op, dev, a, 9'(cnt), shd, ee};
    cmd_valid <= 1'b1;
    @(negedge clk);
    while (!cmd_ready) @(negedge clk);
    @(posedge clk);
    rises = 0;
    cmd_valid <= 1'b0;
    for (int t = 0; t < 60000 && !dn; t++) @(negedge clk);
    if (!dn) begin
      mismatches++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic wr_burst(input logic [7:0] a, input int cnt,
      input logic shd, input logic ee);
    while (wq.size() < cnt) wq.push_back(8'($urandom));
    for (int i = 0; i < cnt; i++) exp_m[8'(a + i)] = wq[i];
    run(OP_WRITE, a, cnt, shd, ee);
    `CHK(er, ERR_NONE)
    `CHK(rises, 9 * (cnt + 2) + 1)
  endtask

  task automatic rd_burst(input logic [7:0] a, input int cnt);
    run(OP_READ, a, cnt, 1'b0, 1'b0);
    `CHK(rq.size(), cnt)
    for (int i = 0; i < cnt; i++) `CHK(rq[i], exp_m[8'(a + i)])
    `CHK(rises, 9 * (cnt + 3) + 2)
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is near 80k cycles; this only cuts a hang
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {arst_n, cmd_valid, wr_valid, frame_busy, slow, dn} = '0;
    {wr_data, cmd} = '0;
    er = ERR_NONE;
    dev = 7'h20;
    for (int i = 0; i < 256; i++) exp_m[i] = fact(i);
    void'($urandom(98));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    wr_valid <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 1 : (k == 2) ? 4 : 1 + $urandom % 3;
      ra = (k == 2) ? 8'hFC : 8'($urandom % 200);
      slow <= k[0];
      wr_burst(ra, n, 1'b0, 1'b0);
      rd_burst(ra, n);
    end
    slow <= 1'b0;
    run(OP_WRITE, 8'hFF, 2, 1'b0, 1'b0);
    `CHK(er, ERR_RANGE)
    `CHK(rises, 0)
    run(OP_READ, 8'h10, 0, 1'b0, 1'b0);
    `CHK(er, ERR_RANGE)
    dev = 7'h21;
    run(OP_READ, 8'h10, 1, 1'b0, 1'b0);
    `CHK(er, ERR_NACK)
    dev = 7'h20;
    wq = {8'h77};
    run(OP_WRITE, 8'hF0, 1, 1'b0, 1'b0);
    `CHK(er, ERR_RESV)
    rd_burst(8'hF0, 1);
    wr_burst(8'h50, 2, 1'b0, 1'b0);
    d0 = busy_cyc;
    wr_burst(8'h50, 2, 1'b0, 1'b1);
    `CHK(busy_cyc - d0 >= 64, 1'b1)
    frame_busy <= 1'b1;
    wr_burst(8'h60, 1, 1'b1, 1'b0);
    cmd <= '{OP_WRITE, dev, 8'h61, 9'h1, 1'b0, 1'b0};
    cmd_valid <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(cmd_ready, 1'b0)
    @(posedge clk);
    frame_busy <= 1'b0;
    wr_burst(8'h61, 1, 1'b0, 1'b0);
    rd_burst(8'h60, 2);
    // Low two bits set on purpose: they must not reach the address
    wq = {8'h57};
    wr_burst(8'hCA, 1, 1'b0, 1'b0);
    run(OP_GC_RELOAD, 8'h00, 0, 1'b0, 1'b0);
    `CHK(er, ERR_NONE)
    dev = 7'h54;
    rd_burst(8'hCA, 1);
    wr_burst(8'h40, 1, 1'b0, 1'b0);
    run(OP_GC_RESET, 8'h00, 0, 1'b0, 1'b0);
    `CHK(er, ERR_NONE)
    dev = 7'h20;
    for (int i = 0; i < 256; i++) exp_m[i] = fact(i);
    rd_burst(8'h3F, 2);
    tally_and_finish();
  end
endmodule // irah_host_tb
